// ===== rtl/adcc_top.v
// Converter control: channel scheduling, result format, compare, DMA.
// Assumes an APB master on clk_sys and an analog front end that presents
// the digitised code of the strobed input on rawCode.
//
// Overview of operation
// - Four channels, own input, result, start.
// - Eight- or twelve-bit result; eight is faster.
// - Left or right adjust, ones or zeros pad.
// - Unsigned or signed sixteen-bit result.
// - New sample accepted while earlier ones convert.
// - Finished result can be handed to DMA.
// - Threshold compare raises flag or event.
// - Event input may start conversions.
// - Single, continuous and scan modes.
// - Eight gain codes, half up to sixty-four.
// - Sixteen pins plus four internal sources.
// - Unity gain stage holds a second input.
// - Four samples fit inside 1.5 microseconds.
// - Latency 3.5 or 2.5 microseconds minimum.
// - Up to two million samples per second.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.vh"
module adcc_top #(
  parameter NCH = 4
) (
  // Clock and reset.
  input wire clk_sys,
  input wire reset,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Event system.
  input wire evTrig,
  output reg [3:0] cmpEvent,
  // Analog front end.
  input wire [11:0] rawCode,
  output reg [4:0] muxSel,
  output reg [2:0] gainSel,
  output reg diffMode,
  output reg sampleStrobe,
  output reg gainHold,
  // Completion and DMA stream.
  output reg [3:0] doneFlag,
  output wire dmaValid,
  output wire [15:0] dmaData,
  output wire [1:0] dmaChan,
  input wire dmaReady
);
  // Control state.
  reg ctrlEn, res8, leftAdj, padOnes, signedRes, contMode, scanMode, evEn;
  reg [3:0] dmaEn;
  reg [11:0] thresh;
  reg [3:0] scanLen;
  reg [3:0] scanIdx;
  reg [11:0] chCfg [0:3];
  reg [15:0] result [0:3];
  reg [3:0] cmpFlag;
  reg [3:0] pending;
  reg [3:0] contMask;
  reg [11:0] rawMeta, rawSync;
  reg [3:0] slotCnt;
  reg slotTick;
  reg [1:0] dmaOut;
  reg pipeInValid;
  reg [14:0] pipeInData;
  wire pipeOutValid;
  wire [14:0] pipeOutData;
  wire bufInReady;
  wire [17:0] bufOut;
  reg [31:0] rdMux;
  reg mapped;
  reg [1:0] pickCh;
  reg [3:0] next_done;
  reg [3:0] next_cmp;

  // Last count of the sample slot divider and the control reset word.
  localparam [31:0] SLOT_LAST = `ADCC_SAMPLE_CYC - 1;
  localparam [15:0] RST_CTRL = `ADCC_RST_CTRL;

  // APB access phase completes on the edge that sees pready high.
  wire apbDone = psel & penable & pready;
  wire apbWr = apbDone & pwrite;
  wire apbRd = apbDone & ~pwrite;
  wire [1:0] regCh = paddr[3:2];
  wire isCfg = (paddr[11:4] == `ADCC_OFF_CHCFG0 >> 4);
  wire isRes = (paddr[11:4] == `ADCC_OFF_RESULT0 >> 4);
  wire ctrlWr = apbWr & (paddr == `ADCC_OFF_CTRL);
  wire [3:0] startWr = ctrlWr ? pwdata[`ADCC_CTRL_START_LSB +: 4] : 4'h0;
  wire [3:0] evStart = (evTrig & evEn) ? 4'hF : 4'h0;

  // Formats a raw code into the sixteen-bit result word.
  function [15:0] fmtRes;
    input [11:0] v;
    input r8, la, p1, sg;
    reg pad;
    begin
      pad = sg ? v[11] : p1;
      if (la) begin
        fmtRes = r8 ? {v[11:4], {8{p1}}} : {v, {4{p1}}};
      end else begin
        fmtRes = r8 ? {{8{pad}}, v[11:4]} : {{4{pad}}, v};
      end
    end
  endfunction

  // Unsigned or signed threshold test; flipping the sign bit orders both.
  function cmpHit;
    input [11:0] v, t;
    input sg, above;
    reg [11:0] a, b;
    begin
      a = v ^ {sg, 11'h000};
      b = t ^ {sg, 11'h000};
      cmpHit = above ? (a > b) : (a < b);
    end
  endfunction

  // The front-end code crosses in through two flip-flops.
  always @(posedge clk_sys) begin
    if (reset) begin
      rawMeta <= 12'h000;
      rawSync <= 12'h000;
    end else begin
      rawMeta <= rawCode;
      rawSync <= rawMeta;
    end
  end

  // Sample slot divider: one sample every 500 ns.
  always @(posedge clk_sys) begin
    if (reset) begin
      slotCnt <= 4'h0;
      slotTick <= 1'b0;
    end else if ({28'h0000000, slotCnt} == SLOT_LAST) begin
      slotCnt <= 4'h0;
      slotTick <= 1'b1;
    end else begin
      slotCnt <= slotCnt + 4'h1;
      slotTick <= 1'b0;
    end
  end

  // Lowest pending channel wins the slot.
  always @* begin
    pickCh = 2'd3;
    if (pending[0]) begin
      pickCh = 2'd0;
    end else if (pending[1]) begin
      pickCh = 2'd1;
    end else if (pending[2]) begin
      pickCh = 2'd2;
    end
  end

  // A DMA-bound sample waits until its buffer place is reserved.
  wire [11:0] pickCfg = chCfg[pickCh];
  wire pickDma = dmaEn[pickCh];
  wire canIssue = ctrlEn & slotTick & (pending != 4'h0) &
                  ~(pickDma & (dmaOut == 2'd2));
  wire scanStep = scanMode & (pickCh == 2'd0);
  wire scanMore = scanStep & (scanIdx != scanLen);

  // Start control, sampling and scan stepping.
  always @(posedge clk_sys) begin
    if (reset) begin
      pending <= 4'h0;
      contMask <= 4'h0;
      scanIdx <= 4'h0;
      muxSel <= 5'h00;
      gainSel <= `ADCC_GAIN_UNITY;
      diffMode <= 1'b0;
      sampleStrobe <= 1'b0;
      gainHold <= 1'b0;
      pipeInValid <= 1'b0;
      pipeInData <= 15'h0000;
    end else begin
      sampleStrobe <= canIssue;
      pipeInValid <= canIssue;
      if ((startWr | evStart) != 4'h0) begin
        contMask <= startWr | evStart;
      end
      if (canIssue) begin
        muxSel <= pickCfg[`ADCC_CH_SEL_LSB +: 5] +
                  (scanStep ? {1'b0, scanIdx} : 5'h00);
        gainSel <= pickCfg[`ADCC_CH_GAIN_LSB +: 3];
        diffMode <= pickCfg[`ADCC_CH_DIFF];
        gainHold <= pickCfg[`ADCC_CH_DIFF] &
                    (pickCfg[`ADCC_CH_GAIN_LSB +: 3] == `ADCC_GAIN_UNITY);
        pipeInData <= {pickDma, pickCh, rawSync};
        scanIdx <= scanMore ? scanIdx + 4'h1 : 4'h0;
      end
      // A start request arriving in the issuing cycle is kept.
      if (canIssue & ~scanMore) begin
        pending <= (pending & ~(4'h1 << pickCh)) | startWr | evStart;
      end else if (ctrlEn & contMode & (pending == 4'h0)) begin
        pending <= contMask | startWr | evStart;
      end else begin
        pending <= pending | startWr | evStart;
      end
    end
  end

  adcc_pipe #(
    .WIDTH(15),
    .LONG(`ADCC_LAT12_CYC),
    .SHORT(`ADCC_LAT8_CYC)
  ) uPipe (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(pipeInValid),
    .inData(pipeInData),
    .shortRes(res8),
    .outValid(pipeOutValid),
    .outData(pipeOutData)
  );

  wire [1:0] outCh = pipeOutData[13:12];
  wire [11:0] outCode = pipeOutData[11:0];
  wire [11:0] outCmpCode = res8 ? {outCode[11:4], 4'h0} : outCode;
  wire [11:0] outCfg = chCfg[outCh];
  wire [15:0] outWord = fmtRes(outCode, res8, leftAdj, padOnes, signedRes);
  wire outHit = outCfg[`ADCC_CH_CMPEN] &
                cmpHit(outCmpCode, thresh, signedRes, outCfg[`ADCC_CH_ABOVE]);
  wire dmaPop = dmaValid & dmaReady;

  // DMA-bound results leave through the buffer; a stall reaches the issue gate.
  adcc_buf2 #(
    .WIDTH(18)
  ) uBuf (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(pipeOutValid & pipeOutData[14]),
    .inReady(bufInReady),
    .inData({outCh, outWord}),
    .outValid(dmaValid),
    .outReady(dmaReady),
    .outData(bufOut)
  );
  assign dmaChan = bufOut[17:16];
  assign dmaData = bufOut[15:0];

  // DMA places held by samples in flight plus words in the buffer.
  always @(posedge clk_sys) begin
    if (reset) begin
      dmaOut <= 2'd0;
    end else if ((canIssue & pickDma) & ~dmaPop) begin
      dmaOut <= dmaOut + 2'd1;
    end else if (dmaPop & ~(canIssue & pickDma)) begin
      dmaOut <= dmaOut - 2'd1;
    end
  end

  // Done and compare flags: a new set wins over any clear.
  always @* begin
    next_done = doneFlag;
    next_cmp = cmpFlag;
    if (apbWr & (paddr == `ADCC_OFF_STATUS)) begin
      next_done = next_done & ~pwdata[`ADCC_STAT_DONE_LSB +: 4];
      next_cmp = next_cmp & ~pwdata[`ADCC_STAT_CMP_LSB +: 4];
    end
    if (apbRd & isRes) begin
      next_done = next_done & ~(4'h1 << regCh);
    end
    if (dmaPop) begin
      next_done = next_done & ~(4'h1 << dmaChan);
    end
    if (pipeOutValid) begin
      next_done = next_done | (4'h1 << outCh);
      next_cmp = next_cmp | ({3'h0, outHit} << outCh);
    end
  end

  // Result storage, flags and compare events per channel.
  always @(posedge clk_sys) begin
    if (reset) begin
      doneFlag <= 4'h0;
      cmpFlag <= 4'h0;
      cmpEvent <= 4'h0;
      result[0] <= 16'h0000;
      result[1] <= 16'h0000;
      result[2] <= 16'h0000;
      result[3] <= 16'h0000;
    end else begin
      doneFlag <= next_done;
      cmpFlag <= next_cmp;
      cmpEvent <= 4'h0;
      if (pipeOutValid) begin
        result[outCh] <= outWord;
        cmpEvent <= {3'h0, outHit & outCfg[`ADCC_CH_CMPEV]} << outCh;
      end
    end
  end

  // Register writes.
  always @(posedge clk_sys) begin
    if (reset) begin
      {dmaEn, evEn, scanMode, contMode, signedRes, padOnes, leftAdj, res8,
       ctrlEn} <= {RST_CTRL[15:12], RST_CTRL[7:0]};
      thresh <= `ADCC_RST_THRESH;
      scanLen <= 4'h0;
      chCfg[0] <= `ADCC_RST_CHCFG;
      chCfg[1] <= `ADCC_RST_CHCFG;
      chCfg[2] <= `ADCC_RST_CHCFG;
      chCfg[3] <= `ADCC_RST_CHCFG;
    end else if (apbWr) begin
      if (paddr == `ADCC_OFF_CTRL) begin
        ctrlEn <= pwdata[`ADCC_CTRL_EN];
        res8 <= pwdata[`ADCC_CTRL_RES8];
        leftAdj <= pwdata[`ADCC_CTRL_LADJ];
        padOnes <= pwdata[`ADCC_CTRL_PAD1];
        signedRes <= pwdata[`ADCC_CTRL_SGN];
        contMode <= pwdata[`ADCC_CTRL_CONT];
        scanMode <= pwdata[`ADCC_CTRL_SCAN];
        evEn <= pwdata[`ADCC_CTRL_EVEN];
        dmaEn <= pwdata[`ADCC_CTRL_DMA_LSB +: 4];
      end
      if (paddr == `ADCC_OFF_THRESH) begin
        thresh <= pwdata[11:0];
      end
      if (paddr == `ADCC_OFF_SCAN) begin
        scanLen <= pwdata[3:0];
      end
      if (isCfg) begin
        chCfg[regCh] <= pwdata[11:0];
      end
    end
  end

  // Read data and decode of mapped addresses.
  always @* begin
    rdMux = 32'h00000000;
    mapped = 1'b1;
    if (paddr == `ADCC_OFF_CTRL) begin
      rdMux = {16'h0000, dmaEn, 4'h0, evEn, scanMode, contMode, signedRes,
               padOnes, leftAdj, res8, ctrlEn};
    end else if (paddr == `ADCC_OFF_STATUS) begin
      rdMux = {23'h000000, (pending != 4'h0), cmpFlag, doneFlag};
    end else if (paddr == `ADCC_OFF_THRESH) begin
      rdMux = {20'h00000, thresh};
    end else if (paddr == `ADCC_OFF_SCAN) begin
      rdMux = {28'h0000000, scanLen};
    end else if (isCfg & (paddr[1:0] == 2'b00)) begin
      rdMux = {20'h00000, chCfg[regCh]};
    end else if (isRes & (paddr[1:0] == 2'b00)) begin
      rdMux = {16'h0000, result[regCh]};
    end else begin
      mapped = 1'b0;
    end
  end

  // One wait state: pready rises in the second access cycle.
  always @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= rdMux;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/adcc_consts.vh
// Constants of the converter control block: timing, offsets, fields.
// Assumes inclusion by the top design file of the block only; definitions only.
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// Clock period and timing figures in nanoseconds.
`define ADCC_CLK_NS 50
`define ADCC_SAMPLE_NS 500
`define ADCC_LAT12_NS 3500
`define ADCC_LAT8_NS 2500
`define ADCC_WIN4_NS 1500
// Cycle counts; least times round up.
`define ADCC_SAMPLE_CYC ((`ADCC_SAMPLE_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_LAT12_CYC ((`ADCC_LAT12_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_LAT8_CYC ((`ADCC_LAT8_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

// Register byte offsets.
`define ADCC_OFF_CTRL 12'h000
`define ADCC_OFF_STATUS 12'h004
`define ADCC_OFF_THRESH 12'h008
`define ADCC_OFF_SCAN 12'h00C
`define ADCC_OFF_CHCFG0 12'h010
`define ADCC_OFF_RESULT0 12'h020

// Control register fields.
`define ADCC_CTRL_EN 0
`define ADCC_CTRL_RES8 1
`define ADCC_CTRL_LADJ 2
`define ADCC_CTRL_PAD1 3
`define ADCC_CTRL_SGN 4
`define ADCC_CTRL_CONT 5
`define ADCC_CTRL_SCAN 6
`define ADCC_CTRL_EVEN 7
`define ADCC_CTRL_START_LSB 8
`define ADCC_CTRL_DMA_LSB 12

// Status register fields.
`define ADCC_STAT_DONE_LSB 0
`define ADCC_STAT_CMP_LSB 4
`define ADCC_STAT_BUSY 8

// Channel configuration fields.
`define ADCC_CH_SEL_LSB 0
`define ADCC_CH_GAIN_LSB 5
`define ADCC_CH_DIFF 8
`define ADCC_CH_CMPEN 9
`define ADCC_CH_ABOVE 10
`define ADCC_CH_CMPEV 11

// Reset values and codes.
`define ADCC_RST_CTRL 16'h0000
`define ADCC_RST_CHCFG 12'h000
`define ADCC_RST_THRESH 12'h000
`define ADCC_GAIN_UNITY 3'h1

`endif

// ===== rtl/adcc_pipe.v
// Conversion pipeline model: carries each sample's tag to its result.
// Assumes one clock, synchronous reset and a new entry at most per cycle.
`timescale 1ns/1ps
`default_nettype none
module adcc_pipe #(
  parameter WIDTH = 15,
  parameter LONG = 70,
  parameter SHORT = 50
) (
  // Clock and reset.
  input wire clk_sys,
  input wire reset,
  // Entry side.
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  input wire shortRes,
  // Exit side.
  output reg outValid,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH:0] stage [0:LONG-2];
  genvar i;

  // First stage takes a new sample even while older ones are in flight.
  always @(posedge clk_sys) begin
    if (reset) begin
      stage[0] <= {(WIDTH+1){1'b0}};
    end else begin
      stage[0] <= {inValid, inData};
    end
  end

  // Every later stage shifts one place per cycle.
  generate
    for (i = 1; i < LONG - 1; i = i + 1) begin : gStage
      always @(posedge clk_sys) begin
        if (reset) begin
          stage[i] <= {(WIDTH+1){1'b0}};
        end else begin
          stage[i] <= stage[i-1];
        end
      end
    end
  endgenerate

  // The short result leaves at an earlier tap.
  always @(posedge clk_sys) begin
    if (reset) begin
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else if (shortRes) begin
      {outValid, outData} <= stage[SHORT-2];
    end else begin
      {outValid, outData} <= stage[LONG-2];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/adcc_buf2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and synchronous reset; the head word sits in slot 0.
`timescale 1ns/1ps
`default_nettype none
module adcc_buf2 #(
  parameter WIDTH = 18
) (
  // Clock and reset.
  input wire clk_sys,
  input wire reset,
  // Filling side.
  input wire inValid,
  output reg inReady,
  input wire [WIDTH-1:0] inData,
  // Draining side.
  output reg outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] slot1;
  reg [1:0] count;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  reg [1:0] next_count;

  // Occupancy after this cycle's push and pop.
  always @* begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 2'd1;
    end else if (pop & ~push) begin
      next_count = count - 2'd1;
    end
  end

  // Words move toward slot 0; full and empty come from the count.
  always @(posedge clk_sys) begin
    if (reset) begin
      count <= 2'd0;
      outValid <= 1'b0;
      inReady <= 1'b1;
      outData <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
    end else begin
      count <= next_count;
      outValid <= (next_count != 2'd0);
      inReady <= (next_count != 2'd2);
      if (pop) begin
        outData <= (count == 2'd2) ? slot1 : inData;
        if (count == 2'd2 && push) begin
          slot1 <= inData;
        end
      end else if (push) begin
        if (count == 2'd0) begin
          outData <= inData;
        end else begin
          slot1 <= inData;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/adcc_front.sv
// Analog front end model: the code that the converter sees on its input.
// Assumes the bench holds the level still across each conversion.
`timescale 1ns/1ps
`default_nettype none
module adcc_front (
  // Level chosen by the bench.
  input wire logic [11:0] level,
  // Code presented to the block.
  output logic [11:0] rawCode
);
  // Every pin and internal source reads the same level here.
  assign rawCode = level;
endmodule
`default_nettype wire

// ===== tb/adcc_top_chk.sv
// Checker for the converter control block, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_chk (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave side.
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Front end, compare and DMA.
  input wire logic [3:0] cmpEvent,
  input wire logic [4:0] muxSel,
  input wire logic [2:0] gainSel,
  input wire logic diffMode,
  input wire logic sampleStrobe,
  input wire logic gainHold,
  input wire logic [3:0] doneFlag,
  input wire logic dmaValid,
  input wire logic [15:0] dmaData,
  input wire logic [1:0] dmaChan,
  input wire logic dmaReady
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Bus answers come two edges after setup and last one cycle.
  a_apb_answer: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("APB answer not on the second edge after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_unmapped_err: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > 12'h02C))
    else $error("error response does not match the address map");

  // Sampling pace, input range and the held second input.
  a_strobe_gap: assert property (sampleStrobe |=>
    !sampleStrobe [*8] ##1 !sampleStrobe)
    else $error("samples closer than ten cycles");
  a_mux_range: assert property (sampleStrobe |-> muxSel <= 5'h13)
    else $error("input select outside the twenty inputs");
  a_gain_hold: assert property (sampleStrobe && diffMode &&
    gainSel == 3'h1 |-> ##[0:1] gainHold)
    else $error("unity gain stage did not hold its input");

  // Completion timing, compare pulses and the held DMA word.
  a_done_latency: assert property (|(doneFlag & ~$past(doneFlag)) |->
    $past(sampleStrobe, 71) || $past(sampleStrobe, 51))
    else $error("completion not at the conversion latency");
  a_cmp_done: assert property (cmpEvent != 4'h0 |->
    (cmpEvent & ~doneFlag) == 4'h0 ##1 cmpEvent == 4'h0)
    else $error("compare event without completion or too long");
  a_dma_hold: assert property (dmaValid && !dmaReady |->
    ##1 dmaValid && $stable({dmaChan, dmaData}))
    else $error("DMA word changed or dropped while stalled");
endmodule

bind adcc_top adcc_top_chk u_adcc_top_chk (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmpEvent(cmpEvent), .muxSel(muxSel), .gainSel(gainSel),
  .diffMode(diffMode), .sampleStrobe(sampleStrobe), .gainHold(gainHold),
  .doneFlag(doneFlag), .dmaValid(dmaValid), .dmaData(dmaData),
  .dmaChan(dmaChan), .dmaReady(dmaReady)
);
`default_nettype wire

// ===== tb/adcc_top_tb_top.sv
// Testbench for the converter control block: APB driver and monitors.
// Assumes the front end model supplies the code chosen by the bench.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, evTrig = 1'b0;
  logic dmaReady = 1'b0;
  logic [11:0] paddr = 12'h000, level = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, sampleStrobe, gainHold, diffMode, dmaValid;
  wire [3:0] cmpEvent, doneFlag;
  wire [11:0] rawCode;
  wire [4:0] muxSel;
  wire [2:0] gainSel;
  wire [15:0] dmaData;
  wire [1:0] dmaChan;
  logic [32:0] rdQ[$];
  logic [32:0] e;
  logic [31:0] dmaQ[$], stQ[$];
  int failures = 0, total_checks = 0, strobeCount = 0, evCount = 0;
  int i, j, n;
  integer seed = 32'hDA7AE03E;

  adcc_top u_adcc_top (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evTrig(evTrig),
    .cmpEvent(cmpEvent), .rawCode(rawCode), .muxSel(muxSel),
    .gainSel(gainSel), .diffMode(diffMode), .sampleStrobe(sampleStrobe),
    .gainHold(gainHold), .doneFlag(doneFlag), .dmaValid(dmaValid),
    .dmaData(dmaData), .dmaChan(dmaChan), .dmaReady(dmaReady));
  adcc_front u_adcc_front (.level(level), .rawCode(rawCode));

  // Clock and a DMA side that stalls at random.
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) dmaReady <= 1'($random(seed));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // One APB transfer; the expected answer is noted first.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] x);
    rdQ.push_back(x);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask

  // Bounded waits on completion flags and on the strobe count.
  task automatic waitDone(input logic [3:0] m);
    int k;
    for (k = 0; k < 400 && (doneFlag & m) !== m; k++) @(posedge clk_sys);
    chk(32'(doneFlag & m), 32'(m), "completion flags");
  endtask
  task automatic waitStrobe(input int t);
    int k;
    for (k = 0; k < 200 && strobeCount < t; k++) @(posedge clk_sys);
    chk(32'(strobeCount), 32'(t), "strobe count");
  endtask

  // Expected result word; f holds signed, pad ones, left, eight bits.
  function automatic logic [15:0] fmt(input logic [11:0] c,
                                      input logic [3:0] f);
    if (f[1])
      return f[0] ? {c[11:4], {8{f[2]}}} : {c, {4{f[2]}}};
    if (f[0])
      return f[3] ? {{8{c[11]}}, c[11:4]} : {{8{f[2]}}, c[11:4]};
    return f[3] ? {{4{c[11]}}, c} : {{4{f[2]}}, c};
  endfunction

  // Takes the oldest note for each answer, word and sample seen.
  always @(posedge clk_sys) begin
    if (!reset && pready) begin
      e = rdQ.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]}, "error response");
      if (!pwrite)
        chk(prdata, e[31:0], "read data");
    end
    if (!reset && dmaValid && dmaReady)
      chk({14'h0, dmaChan, dmaData}, dmaQ.pop_front(), "dma word");
    if (!reset && sampleStrobe) begin
      chk({23'h0, muxSel, gainSel, diffMode}, stQ.pop_front(), "sample");
      strobeCount++;
    end
    if (cmpEvent[0] === 1'b1)
      evCount++;
  end

  task automatic end_sim();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values, then unmapped places refused.
    for (i = 0; i < 12; i++) rd(12'(4 * i), 32'h0);
    apb(1'b0, 12'hFFC, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h030, 32'hFFFF, {1'b1, 32'h0});
    // Every result format on channel 0, flag cleared by the read.
    wr(12'h010, 32'h0);
    for (i = 0; i < 16; i++) begin
      level <= 12'($random(seed));
      stQ.push_back(32'h0);
      wr(12'h000, 32'h101 | 32'(i << 1));
      waitDone(4'h1);
      // Let a short sample clear the long tap before the width changes.
      repeat (20) @(posedge clk_sys);
      rd(12'h020, {16'h0, fmt(level, 4'(i))});
      rd(12'h004, 32'h0);
    end
    // Four channels started together, served in order, sent by DMA.
    level <= 12'($random(seed));
    for (i = 0; i < 4; i++) begin
      wr(12'(16 + 4 * i), 32'(35 * i + 1));
      rd(12'(16 + 4 * i), 32'(35 * i + 1));
      stQ.push_back(32'(((3 * i + 1) << 4) | (i << 1)));
      dmaQ.push_back({14'h0, 2'(i), 4'h0, level});
    end
    wr(12'h000, 32'hFF01);
    for (n = 0; n < 800 && dmaQ.size() > 0; n++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk(32'(doneFlag), 32'h0, "flags after dma");
    // Event start of all channels, channel 0 differential across every gain code.
    wr(12'h000, 32'h81);
    for (i = 0; i < 8; i++) begin
      wr(12'h010, 32'h102 | 32'(i << 5));
      stQ.push_back(32'h21 | 32'(i << 1));
      for (j = 1; j < 4; j++) stQ.push_back(32'(((3 * j + 1) << 4) | (j << 1)));
      @(posedge clk_sys);
      evTrig <= 1'b1;
      @(posedge clk_sys);
      evTrig <= 1'b0;
      waitDone(4'hF);
      wr(12'h004, 32'hF);
    end
    // Threshold compare above then below, with its event pulse.
    level <= 12'h800;
    wr(12'h008, 32'h7FF);
    wr(12'h010, 32'hE00);
    for (i = 0; i < 2; i++) begin
      stQ.push_back(32'h0);
      n = evCount;
      wr(12'h000, 32'h101);
      waitDone(4'h1);
      rd(12'h004, i ? 32'h1 : 32'h11);
      chk(32'(evCount - n), 32'(1 - i), "compare events");
      wr(12'h004, 32'hFF);
      wr(12'h010, 32'hA00);
    end
    // Scan steps channel 0 through four inputs; continuous repeats.
    wr(12'h00C, 32'h3);
    wr(12'h010, 32'h4);
    for (i = 4; i < 8; i++) stQ.push_back(32'(i << 4));
    n = strobeCount + 4;
    wr(12'h000, 32'h141);
    waitStrobe(n);
    waitDone(4'h1);
    for (i = 0; i < 3; i++) stQ.push_back(32'h40);
    n = strobeCount + 3;
    wr(12'h000, 32'h121);
    waitStrobe(n);
    wr(12'h000, 32'h0);
    repeat (100) @(posedge clk_sys);
    chk(32'(stQ.size()), 32'h0, "samples after stop");
    end_sim();
  end
endmodule
`default_nettype wire
